//--- mts_pkg.sv
// Shared constants, types and helpers of the memory transaction scheduler
// Overview of operation
// R01: Arbiter offers one request, next after done
// R02: Reset or low-byte config write restarts init
// R03: Must urgency: refresh repeatedly down to release
// R04: Reads come next after must refresh
// R05: Need urgency: one refresh before writes
// R06: Writes only after must, reads, need
// R07: May or release urgency: one refresh
// R08: Self-refresh request enters self-refresh, lowest
// R09: After each action re-evaluate from top
// R10: Self-refresh: no refreshes, no priority scheme
// R11: Software bounds async request length
// R12: Max sixteen words, one cycle per unit
// R13: Async phases, wait extends up to limit
// R14: Cache fills complete first, others held
// R15: High-priority requesters avoid persistent streams
// R16: SDRAM in self-refresh before clock gating
// R17: Power-down: clock enable low except refresh
// R18: Pure DMA target, no DMA events
// R19: Top-byte config write skips init
// R20: Backlog counts ticks and refreshes, four levels
package mts_pkg;

   // Clock and timing counts
   localparam int CLK_PERIOD_NS         = 50;
   localparam int INIT_TIME_US          = 200;
   localparam int INIT_CYCLES           = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int REFRESH_TIME_NS       = 70;
   localparam int REFRESH_CYCLES        = (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SDRAM_OVERHEAD_CYCLES = 4;
   localparam int CNT_WIDTH             = 13;
   localparam logic [CNT_WIDTH-1:0] INIT_COUNT    = CNT_WIDTH'(INIT_CYCLES);
   localparam logic [CNT_WIDTH-1:0] REFRESH_COUNT = CNT_WIDTH'(REFRESH_CYCLES);

   // Request sizes
   localparam logic [4:0] MAX_REQ_WORDS   = 5'h10;
   localparam logic [4:0] FILL_WORDS      = 5'h08;
   localparam logic [6:0] MAX_ASYNC_UNITS = 7'h40;

   // Byte lanes of the configuration register that restart initialization
   localparam logic [3:0] CFG_INIT_BYTE_MASK = 4'h7;

   // Refresh backlog counter and urgency thresholds
   localparam int         BACKLOG_WIDTH = 4;
   localparam int         BACKLOG_MAX   = 15;
   localparam logic [3:0] URG_MAY_AT    = 4'h4;
   localparam logic [3:0] URG_NEED_AT   = 4'h7;
   localparam logic [3:0] URG_MUST_AT   = 4'hb;

   typedef enum logic [2:0] {URG_NONE, URG_RELEASE, URG_MAY, URG_NEED, URG_MUST} mts_urgency_t;
   typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_REFRESH, ST_SDRAM, ST_ASYNC, ST_SELFREF}
      mts_state_t;
   typedef enum logic [1:0] {ASP_SETUP, ASP_STROBE, ASP_HOLD, ASP_TURN} mts_phase_t;

   // Urgency level of a backlog count
   function automatic mts_urgency_t mts_urgency(input logic [BACKLOG_WIDTH-1:0] count);
      if (count >= URG_MUST_AT)
         return URG_MUST;
      else if (count >= URG_NEED_AT)
         return URG_NEED;
      else if (count >= URG_MAY_AT)
         return URG_MAY;
      else if (count != 4'h0)
         return URG_RELEASE;
      else
         return URG_NONE;
   endfunction

   // Access cycles of an async request: one per bus-width unit of 32-bit words
   function automatic logic [6:0] mts_async_units(input logic [4:0] words,
                                                  input logic       wide16);
      logic [4:0] w;
      w = (words == 5'h00) ? 5'h01 : ((words > MAX_REQ_WORDS) ? MAX_REQ_WORDS : words);
      return wide16 ? {1'b0, w, 1'b0} : {w, 2'b00};
   endfunction

endpackage

//--- mts_refresh_backlog.sv
// Refresh backlog counter of the memory transaction scheduler
`timescale 1ns/1ps
`default_nettype none
module mts_refresh_backlog #(
   parameter int MAX_COUNT = mts_pkg::BACKLOG_MAX
) (
   input  wire logic                             clk_sys,
   input  wire logic                             sys_rst,
   input  wire logic                             intervalTick,
   input  wire logic                             refreshIssued,
   input  wire logic                             holdCount,
   input  wire logic                             clearCount,
   output logic [mts_pkg::BACKLOG_WIDTH-1:0]     backlog
);
   import mts_pkg::*;

   localparam logic [BACKLOG_WIDTH-1:0] MAX_VAL = BACKLOG_WIDTH'(MAX_COUNT);

   if (MAX_COUNT < 11 || MAX_COUNT >= (1 << BACKLOG_WIDTH)) begin : g_bad_max
      $error("Backlog maximum must reach must urgency and fit the counter");
   end

   // Up on interval expiry, down on issued refresh; both at once cancel out
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         backlog <= 4'h0;
      end else if (clearCount) begin
         backlog <= 4'h0;
      end else begin
         if (intervalTick && !holdCount && !refreshIssued && backlog != MAX_VAL) begin // R20
            backlog <= backlog + 4'h1;
         end else if (refreshIssued && !(intervalTick && !holdCount) && backlog != 4'h0) begin
            backlog <= backlog - 4'h1; // R20
         end
      end
   end

endmodule
`default_nettype wire

//--- mts_scheduler.sv
// Transaction scheduler top: priority selection, async cycle engine, clock enable
`timescale 1ns/1ps
`default_nettype none
module mts_scheduler #(
   parameter int SDRAM_OVERHEAD = mts_pkg::SDRAM_OVERHEAD_CYCLES
) (
   input  wire logic                          clk_sys,
   input  wire logic                          sys_rst,
   input  wire logic                          cfgWrite,
   input  wire logic [3:0]                    cfgByteEn,
   input  wire logic                          selfRefreshRequestBit,
   input  wire logic                          powerDownRequestBit,
   input  wire logic                          refreshTick,
   input  wire logic                          reqValid,
   input  wire logic                          reqWrite,
   input  wire logic                          reqAsync,
   input  wire logic [4:0]                    reqWords,
   input  wire logic                          fillValid,
   input  wire logic                          fillAsync,
   input  wire logic                          busWidth16,
   input  wire logic [3:0]                    asyncSetup,
   input  wire logic [3:0]                    asyncStrobe,
   input  wire logic [3:0]                    asyncHold,
   input  wire logic [3:0]                    asyncTurn,
   input  wire logic                          extendedWaitEnable,
   input  wire logic                          waitPolarity,
   input  wire logic [7:0]                    maxExtWait,
   input  wire logic                          externalWaitInput,
   input  wire logic                          clockStopRequest,
   output logic                               reqDone,
   output logic                               fillDone,
   output logic                               autoRefreshCommand,
   output logic                               rowActivateCommand,
   output logic                               sdramClockEnablePin,
   output logic                               asyncStrobeActive,
   output logic                               asyncWaitTimeout,
   output logic                               initBusy,
   output logic                               selfRefreshActive,
   output logic                               clockStopAck,
   output logic                               dmaEvent,
   output logic [mts_pkg::BACKLOG_WIDTH-1:0]  refreshBacklog
);
   import mts_pkg::*;

   if (SDRAM_OVERHEAD < 1 || SDRAM_OVERHEAD > 64) begin : g_bad_overhead
      $error("SDRAM access overhead must be between 1 and 64 cycles");
   end

   mts_state_t       state;
   mts_state_t       pick;
   mts_phase_t       phase;
   mts_urgency_t     urg;
   logic [12:0]      cnt;
   logic [12:0]      sdramLen;
   logic [3:0]       phaseCnt;
   logic [7:0]       extCount;
   logic [6:0]       unitIdx;
   logic [6:0]       unitsTotal;
   logic [4:0]       curWords;
   logic             curWrite;
   logic             curFill;
   logic             mustBurst;
   logic             cfgInit;
   logic             served;
   logic             readPending;
   logic             writePending;
   logic             waitActive;
   logic             asyncLast;
   logic             sdramLast;
   logic             finishing;

   // Backlog ticks are ignored in self-refresh: the memory refreshes itself
   mts_refresh_backlog #(
      .MAX_COUNT     (BACKLOG_MAX)
   ) u_backlog (
      .clk_sys       (clk_sys),
      .sys_rst       (sys_rst),
      .intervalTick  (refreshTick),
      .refreshIssued (autoRefreshCommand),
      .holdCount     (state == ST_SELFREF),
      .clearCount    (state == ST_INIT),
      .backlog       (refreshBacklog)
   );

   // Request and urgency decode
   assign urg          = mts_urgency(refreshBacklog);
   assign cfgInit      = cfgWrite && ((cfgByteEn & CFG_INIT_BYTE_MASK) != 4'h0); // R02 R19
   // A request just answered may still be up for a cycle; do not serve it twice
   assign served       = reqDone || fillDone; // R01
   assign readPending  = !served && (fillValid || (reqValid && !reqWrite));
   // Other requests wait while a cache fill is offered
   assign writePending = !served && !fillValid && reqValid && reqWrite; // R14
   assign waitActive   = extendedWaitEnable && (externalWaitInput == waitPolarity);
   assign sdramLen     = 13'(curWords) + 13'(SDRAM_OVERHEAD - 1);
   assign sdramLast    = (state == ST_SDRAM) && (cnt == sdramLen);
   assign asyncLast    = (state == ST_ASYNC) && (phase == ASP_TURN) && (phaseCnt == asyncTurn)
                         && (unitIdx == unitsTotal - 7'h01);
   assign finishing    = (sdramLast || asyncLast) && !cfgInit;

   // Strict priority order, evaluated afresh each time the scheduler is idle
   always_comb begin
      pick = ST_IDLE;
      if (mustBurst || urg == URG_MUST) begin
         pick = ST_REFRESH; // R03
      end else if (readPending) begin
         pick = (fillValid ? fillAsync : reqAsync) ? ST_ASYNC : ST_SDRAM; // R04 R14
      end else if (urg == URG_NEED) begin
         pick = ST_REFRESH; // R05
      end else if (writePending) begin
         pick = reqAsync ? ST_ASYNC : ST_SDRAM; // R06
      end else if (urg != URG_NONE) begin
         pick = ST_REFRESH; // R07
      end else if (selfRefreshRequestBit) begin
         pick = ST_SELFREF; // R08
      end
   end

   // Main sequencer; a qualifying config write preempts whatever runs
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_INIT;
         cnt   <= 13'h0000;
      end else if (cfgInit) begin
         state <= ST_INIT; // R02
         cnt   <= 13'h0000;
      end else begin
         unique case (state)
            ST_INIT: begin
               if (cnt == INIT_COUNT - 13'h0001) begin
                  state <= ST_IDLE;
                  cnt   <= 13'h0000;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            ST_IDLE: begin
               state <= pick; // R09
               cnt   <= 13'h0000;
            end
            ST_REFRESH: begin
               if (cnt == REFRESH_COUNT - 13'h0001) begin
                  state <= ST_IDLE; // R09
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            ST_SDRAM: begin
               if (sdramLast) begin
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            ST_ASYNC: begin
               if (asyncLast) begin
                  state <= ST_IDLE;
               end
            end
            ST_SELFREF: begin
               // No refresh and no scheduling until software drops the request
               if (!selfRefreshRequestBit) begin // R10
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Latch the request being served
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         curWords <= 5'h01;
         curWrite <= 1'b0;
         curFill  <= 1'b0;
      end else if (state == ST_IDLE && (pick == ST_SDRAM || pick == ST_ASYNC)) begin
         curFill  <= readPending && fillValid;
         curWrite <= !readPending;
         curWords <= (readPending && fillValid) ? FILL_WORDS : reqWords; // R12
      end
   end

   // Must urgency holds the burst until the backlog is down to release
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mustBurst <= 1'b0;
      end else if (state == ST_INIT || cfgInit) begin
         mustBurst <= 1'b0;
      end else if (urg == URG_MUST) begin
         mustBurst <= 1'b1; // R03
      end else if (urg <= URG_RELEASE) begin
         mustBurst <= 1'b0; // R03
      end
   end

   // Async engine: setup, strobe, hold, turnaround per bus-width unit
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase      <= ASP_SETUP;
         phaseCnt   <= 4'h0;
         extCount   <= 8'h00;
         unitIdx    <= 7'h00;
         unitsTotal <= 7'h01;
      end else if (state == ST_IDLE) begin
         phase      <= ASP_SETUP;
         phaseCnt   <= 4'h0;
         extCount   <= 8'h00;
         unitIdx    <= 7'h00;
         unitsTotal <= mts_async_units((readPending && fillValid) ? FILL_WORDS : reqWords,
                                       busWidth16); // R12
      end else if (state == ST_ASYNC) begin
         unique case (phase)
            ASP_SETUP: begin
               if (phaseCnt == asyncSetup) begin
                  phase    <= ASP_STROBE; // R13
                  phaseCnt <= 4'h0;
                  extCount <= 8'h00;
               end else begin
                  phaseCnt <= phaseCnt + 4'h1;
               end
            end
            ASP_STROBE: begin
               if (phaseCnt != asyncStrobe) begin
                  phaseCnt <= phaseCnt + 4'h1;
               end else if (waitActive && extCount != maxExtWait) begin
                  extCount <= extCount + 8'h01; // R13
               end else begin
                  phase    <= ASP_HOLD;
                  phaseCnt <= 4'h0;
               end
            end
            ASP_HOLD: begin
               if (phaseCnt == asyncHold) begin
                  phase    <= ASP_TURN;
                  phaseCnt <= 4'h0;
               end else begin
                  phaseCnt <= phaseCnt + 4'h1;
               end
            end
            ASP_TURN: begin
               if (phaseCnt != asyncTurn) begin
                  phaseCnt <= phaseCnt + 4'h1;
               end else if (unitIdx != unitsTotal - 7'h01) begin
                  unitIdx  <= unitIdx + 7'h01; // R12
                  phase    <= ASP_SETUP;
                  phaseCnt <= 4'h0;
               end
            end
         endcase
      end
   end

   // Completion strobes; a fill answers on its own port
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reqDone  <= 1'b0;
         fillDone <= 1'b0;
      end else begin
         reqDone  <= finishing && !curFill; // R01
         fillDone <= finishing && curFill; // R14
      end
   end

   // Command strobes and async status, registered one cycle behind the decision
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         autoRefreshCommand <= 1'b0;
         rowActivateCommand <= 1'b0;
         asyncStrobeActive  <= 1'b0;
         asyncWaitTimeout   <= 1'b0;
      end else begin
         autoRefreshCommand <= (state == ST_IDLE) && (pick == ST_REFRESH) && !cfgInit; // R20
         rowActivateCommand <= (state == ST_IDLE) && (pick == ST_SDRAM) && !cfgInit;
         asyncStrobeActive  <= (state == ST_ASYNC) && (phase == ASP_STROBE) && !cfgInit;
         asyncWaitTimeout   <= (state == ST_ASYNC) && (phase == ASP_STROBE)
                               && (phaseCnt == asyncStrobe) && waitActive
                               && (extCount == maxExtWait) && !cfgInit; // R13
      end
   end

   // Clock enable low in self-refresh and while idle in power-down;
   // a pending refresh or request raises it again for its own command
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sdramClockEnablePin <= 1'b0;
      end else begin
         sdramClockEnablePin <= cfgInit
            || !(((state == ST_IDLE) && (pick == ST_SELFREF))
                 || ((state == ST_SELFREF) && selfRefreshRequestBit)
                 || ((state == ST_IDLE) && (pick == ST_IDLE) && powerDownRequestBit)); // R17
      end
   end

   // Status flags; the clock may be gated only once the memory refreshes itself,
   // and both flags drop with the request so they never overlap a rising clock enable
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         initBusy          <= 1'b1;
         selfRefreshActive <= 1'b0;
         clockStopAck      <= 1'b0;
         dmaEvent          <= 1'b0;
      end else begin
         initBusy          <= (state == ST_INIT) || cfgInit;
         selfRefreshActive <= (state == ST_SELFREF) && selfRefreshRequestBit && !cfgInit;
         clockStopAck      <= (state == ST_SELFREF) && selfRefreshRequestBit && clockStopRequest
                              && !cfgInit; // R16
         dmaEvent          <= 1'b0; // R18
      end
   end

   // Checks on the scheduling decisions and the pins
   a_init_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cfgInit |=> (state == ST_INIT) && initBusy) // R02
      else $error("config write did not restart init");
   a_top_byte_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgWrite && cfgByteEn == 4'h8 && state != ST_INIT) |=> state != ST_INIT) // R19
      else $error("top byte write restarted init");
   a_must_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && urg == URG_MUST && readPending)
      |=> state == ST_REFRESH ##0 autoRefreshCommand) // R03
      else $error("must refresh lost to a read");
   a_read_second: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && !mustBurst && urg != URG_MUST && readPending)
      |=> (state == ST_SDRAM || state == ST_ASYNC) && !curWrite) // R04
      else $error("read not served next");
   a_need_third: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && !mustBurst && urg == URG_NEED && !readPending
       && writePending) |=> state == ST_REFRESH) // R05
      else $error("write overtook need refresh");
   a_write_fourth: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((state == ST_SDRAM || state == ST_ASYNC) && curWrite && $past(state) == ST_IDLE)
      |-> $past(urg) < URG_NEED && !$past(mustBurst)) // R06
      else $error("write started with refresh pending");
   a_idle_refresh: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && !readPending && !writePending && urg != URG_NONE)
      |=> state == ST_REFRESH) // R07
      else $error("backlog left unserved while idle");
   a_selfref_last: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && $past(state) != ST_IDLE && selfRefreshRequestBit
       && urg == URG_NONE && !readPending && !writePending)
      |=> state == ST_SELFREF ##1 selfRefreshActive) // R08 R09
      else $error("self-refresh not entered");
   a_selfref_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
      selfRefreshActive |-> !autoRefreshCommand && !sdramClockEnablePin) // R10 R16
      else $error("activity during self-refresh");
   a_wait_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_ASYNC) |-> extCount <= maxExtWait && unitIdx < MAX_ASYNC_UNITS) // R12 R13
      else $error("async cycle beyond its limits");
   a_fill_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && fillValid && !served && !mustBurst
       && urg != URG_MUST) |=> curFill && curWords == FILL_WORDS) // R14
      else $error("cache fill not served first");
   a_powerdown_cke: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE && !cfgInit && pick == ST_IDLE && powerDownRequestBit)
      |=> !sdramClockEnablePin) // R17
      else $error("clock enable high while powered down");
   a_refresh_cke: assert property (@(posedge clk_sys) disable iff (sys_rst)
      autoRefreshCommand |-> sdramClockEnablePin) // R17
      else $error("refresh issued with clock enable low");
   a_no_dma: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !dmaEvent) // R18
      else $error("DMA event raised");

endmodule
`default_nettype wire

//--- mts_mem_model.sv
// External memory model: answers the async strobe on the wait line
`timescale 1ns/1ps
`default_nettype none
module mts_mem_model (
   input  wire logic clk_sys,
   input  wire logic asyncStrobeActive,
   input  wire logic waitPolarity,
   input  wire logic stall,
   output logic      externalWaitInput
);
   // Wait follows the strobe one cycle late; a strobe of three cycles or more hits the limit
   initial externalWaitInput = 1'h1;
   always @(posedge clk_sys)
      externalWaitInput <= (stall && asyncStrobeActive) ? waitPolarity : !waitPolarity;
endmodule
`default_nettype wire

//--- mts_scheduler_bench.sv
// Self-checking bench of the memory transaction scheduler
`timescale 1ns/1ps
`default_nettype none
module mts_scheduler_bench;
   import mts_pkg::*;
   logic       clk_sys = '0, sys_rst = '1, cfgWrite = '0, selfRefreshRequestBit = '0;
   logic       powerDownRequestBit = '0, refreshTick = '0, reqValid = '0, reqWrite = '0;
   logic       reqAsync = '0, fillValid = '0, busWidth16 = '0, clockStopRequest = '0, stall = '0;
   logic [3:0] cfgByteEn = '0, asyncSetup = '0, asyncStrobe = '0, asyncHold = '0, asyncTurn = '0;
   logic [4:0] reqWords = 5'h01;
   logic       fillAsync = '0;
   logic       reqDone, fillDone, autoRefreshCommand, rowActivateCommand, sdramClockEnablePin;
   logic       asyncStrobeActive, asyncWaitTimeout, initBusy, selfRefreshActive, clockStopAck;
   logic       dmaEvent, externalWaitInput;
   logic [3:0] refreshBacklog, bAct;
   int         n_errors, cmp_count, nStb, nTo, nRef, cyc, tAct, tDone, tFill;

   mts_scheduler dut (.clk_sys, .sys_rst, .cfgWrite, .cfgByteEn, .selfRefreshRequestBit,
      .powerDownRequestBit, .refreshTick, .reqValid, .reqWrite, .reqAsync, .reqWords, .fillValid,
      .fillAsync, .busWidth16, .asyncSetup, .asyncStrobe, .asyncHold, .asyncTurn,
      .extendedWaitEnable(1'h1), .waitPolarity(1'h1), .maxExtWait(8'h05), .externalWaitInput,
      .clockStopRequest, .reqDone, .fillDone, .autoRefreshCommand, .rowActivateCommand,
      .sdramClockEnablePin, .asyncStrobeActive, .asyncWaitTimeout, .initBusy,
      .selfRefreshActive, .clockStopAck, .dmaEvent, .refreshBacklog);
   mts_mem_model mem (.clk_sys, .asyncStrobeActive, .waitPolarity(1'h1), .stall,
      .externalWaitInput);

   always #25 clk_sys = !clk_sys;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic waitFor(ref logic s, input logic v, input int lim);
      int i = 0;
      do @(negedge clk_sys); while (s !== v && ++i < lim);
      if (i == lim) begin
         n_errors++;
         summarize();
      end
   endtask

   // Event log at mid-cycle, settled and ahead of the tasks; refresh must wake clock enable
   always @(negedge clk_sys) begin
      cyc++;
      nStb += asyncStrobeActive;
      nTo += asyncWaitTimeout;
      nRef += autoRefreshCommand;
      if (rowActivateCommand)
         tAct = cyc;
      if (rowActivateCommand)
         bAct = refreshBacklog;
      if (reqDone)
         tDone = cyc;
      if (fillDone)
         tFill = cyc;
      if (autoRefreshCommand && powerDownRequestBit)
         chk(sdramClockEnablePin, 16'h1);
      chk(dmaEvent, 16'h0);
   end

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys) refreshTick <= '1;
         @(posedge clk_sys) refreshTick <= '0;
      end
   endtask

   // One request at a time, dropped on the edge after its answer
   task automatic req(input logic w, input logic a, input logic [4:0] n);
      @(posedge clk_sys) reqValid <= '1;
      reqWrite <= w;
      reqAsync <= a;
      reqWords <= n;
      waitFor(reqDone, '1, 20000);
      @(posedge clk_sys) reqValid <= '0;
   endtask

   function automatic int units(input int n);
      return busWidth16 ? n * 2 : n * 4;
   endfunction

   initial begin
      int n, s0;
      void'($urandom(32'h0228bd7e));
      repeat (5) @(posedge clk_sys);
      sys_rst <= '0;
      @(negedge clk_sys) chk(initBusy, 16'h1);
      waitFor(initBusy, '0, 5000);
      // SDRAM transfers, longest and shortest first
      for (int i = 0; i < 6; i++) begin
         n = (i == 0) ? 16 : (i == 1) ? 1 : $urandom_range(16, 1);
         req(i[0], '0, 5'(n));
         chk(16'(tDone - tAct), 16'(n + SDRAM_OVERHEAD_CYCLES));
      end
      $display("sdram test done");
      // Async transfers: strobe cycles follow units and programmed strobe
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys) {busWidth16, asyncStrobe} <= {i[0], 4'($urandom_range(3, 0))};
         {asyncSetup, asyncHold, asyncTurn} <= 12'($urandom) & 12'h333;
         n = (i == 0) ? 16 : $urandom_range(16, 1);
         s0 = nStb;
         req(i[1], '1, 5'(n));
         chk(16'(nStb - s0), 16'(units(n) * (asyncStrobe + 1)));
      end
      $display("async test done");
      // Stalled 64-unit write while backlog climbs to must level
      @(posedge clk_sys) stall <= '1;
      busWidth16 <= '0;
      asyncStrobe <= 4'h3;
      s0 = nTo;
      fork
         req('1, '1, 5'h10);
         tick(12);
      join
      chk(16'(nTo - s0), 16'(units(16)));
      req('0, '0, 5'h04);
      chk(bAct, 16'h3);
      repeat (20) @(negedge clk_sys);
      chk(refreshBacklog, 16'h0);
      fork
         req('1, '1, 5'h10);
         tick(8);
      join
      req('1, '0, 5'h02);
      chk(bAct, 16'h6);
      $display("refresh priority test done");
      // Self-refresh after pending refreshes, then clock stop
      @(posedge clk_sys) stall <= '0;
      selfRefreshRequestBit <= '1;
      clockStopRequest <= '1;
      waitFor(clockStopAck, '1, 200);
      chk(selfRefreshActive, 16'h1);
      chk(sdramClockEnablePin, 16'h0);
      s0 = nRef;
      tick(3);
      @(negedge clk_sys) chk(16'(nRef - s0), 16'h0);
      @(posedge clk_sys) selfRefreshRequestBit <= '0;
      clockStopRequest <= '0;
      repeat (20) @(posedge clk_sys);
      // Power-down: clock enable low, woken only for refresh
      powerDownRequestBit <= '1;
      repeat (10) @(negedge clk_sys);
      chk(sdramClockEnablePin, 16'h0);
      tick(1);
      waitFor(autoRefreshCommand, '1, 20);
      repeat (10) @(negedge clk_sys);
      chk(sdramClockEnablePin, 16'h0);
      @(posedge clk_sys) powerDownRequestBit <= '0;
      $display("power test done");
      // Cache fill raised with a request on the same edge finishes first
      fork
         req('0, '0, 5'h03);
         begin
            @(posedge clk_sys) fillValid <= '1;
            fillAsync <= 1'($urandom);
            waitFor(fillDone, '1, 2000);
            @(posedge clk_sys) fillValid <= '0;
         end
      join
      chk(16'(tFill < tDone), 16'h1);
      // Top-byte config write leaves init alone, low bytes restart it
      @(posedge clk_sys) {cfgWrite, cfgByteEn} <= {1'h1, 4'h8};
      @(posedge clk_sys) cfgWrite <= '0;
      repeat (3) @(negedge clk_sys);
      chk(initBusy, 16'h0);
      @(posedge clk_sys) {cfgWrite, cfgByteEn} <= {1'h1, 4'($urandom_range(7, 1))};
      @(posedge clk_sys) cfgWrite <= '0;
      repeat (2) @(negedge clk_sys);
      chk(initBusy, 16'h1);
      waitFor(initBusy, '0, 5000);
      $display("fill and config test done");
      summarize();
   end
endmodule
`default_nettype wire
